//--- pkg/sac_defines.svh
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// command word layout
`define SAC_WORD_W 16
`define SAC_BYTE_W 8
`define SAC_ADDR_MSB 15
`define SAC_ADDR_LSB 8
`define SAC_ATTN_MSB 7
`define SAC_ATTN_LSB 0

// channel addresses
`define SAC_CH_COUNT 2
`define SAC_ADDR_CH0 8'h00
`define SAC_ADDR_CH1 8'h01

// attenuation codes
`define SAC_CODE_MUTE_MIN 8'h7F
`define SAC_CODE_HALF_MAX 8'h5F
`define SAC_CODE_FINE_BASE 8'h60
`define SAC_TAP_FINE_BASE 8'h60
`define SAC_TAP_MUTE 8'hFF

// reset values
`define SAC_WORD_RST 16'h0000
`define SAC_ACK_RST 1'b0

// warm-up after reset, in core cycles
`define SAC_WARM_W 2
`define SAC_WARM_RST 2'h0
`define SAC_WARM_STEP 2'h1
`define SAC_WARM_DONE 2'h3

`endif

//--- pkg/sac_pkg.sv
package sac_pkg;
    // per-channel state of the tap switch bank
    typedef enum logic [1:0] {
        SAC_CH_MUTED = 2'b00,
        SAC_CH_TAPPED = 2'b01
    } sac_ch_mode_t;
endpackage

//--- src/sac_sync.sv
`timescale 1ns/1ps
// two flip-flop level synchroniser
module sac_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // level in, level out
    input wire logic d_i,
    output logic q_o
);
    logic meta_reg; // first stage, read only by second
    logic meta_next;
    logic q_reg;
    logic q_next;

    // next values
    always_comb begin
        meta_next = d_i;
        q_next = meta_reg;
    end

    // register stages
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            q_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule // sac_sync

//--- src/sac_shifter.sv
`timescale 1ns/1ps
`include "sac_defines.svh"
// link-side shift register on the shift clock, holding latch on the rising strobe
module sac_shifter (
    // link clock and pins
    input wire logic shift_clk_i,
    input wire logic latch_i,
    input wire logic data_i,
    // chain output
    output logic chain_o,
    // captured word and capture toggle
    output logic [`SAC_WORD_W-1:0] word_o,
    output logic cap_tgl_o
);
    logic [`SAC_WORD_W-1:0] shift_reg; // serial shift register
    logic [`SAC_WORD_W-1:0] shift_next;
    logic [`SAC_WORD_W-1:0] hold_reg; // holding latch
    logic [`SAC_WORD_W-1:0] hold_next;
    // toggle starts at a fixed value so first capture is seen
    logic tgl_reg = `SAC_ACK_RST; // flips once per capture
    logic tgl_next;

    // shift while strobe low, msb first
    always_comb begin
        shift_next = shift_reg;
        if (!latch_i) begin
            shift_next = {shift_reg[`SAC_WORD_W-2:0], data_i};
        end
    end

    always_ff @(posedge shift_clk_i) begin
        shift_reg <= shift_next;
    end

    // strobe high: shift clocks leave the register alone
    property p_no_shift;
        @(posedge shift_clk_i)
        latch_i |=> $stable(shift_reg);
    endproperty
    a_no_shift: assert property (p_no_shift) else $error("shifted with strobe high");

    // capture on rising strobe, no shift clock needed
    always_comb begin
        hold_next = shift_reg;
        tgl_next = ~tgl_reg;
    end

    always_ff @(posedge latch_i) begin
        hold_reg <= hold_next;
        tgl_reg <= tgl_next;
    end

    // far-end stage feeds the next device directly, so n devices take 16n clocks
    assign chain_o = shift_reg[`SAC_WORD_W-1];
    assign word_o = hold_reg;
    assign cap_tgl_o = tgl_reg;
endmodule // sac_shifter

//--- src/sac_core.sv
`timescale 1ns/1ps
`include "sac_defines.svh"
//
// Overview of operation
// - shift data in while strobe is low
// - far-end bit leaves on chain output
// - rising strobe captures shift register word
// - decode word, select one tap
// - only addressed channel changes its setting
// - all channels muted after power-up
// - independent tap selection per channel
// - chain output feeds next device input
// - chained devices latch together, decode own
// - muted channel fully disconnects input
// - word is address byte, attenuation byte
// - msb first, address byte first
// - codes 7F and above mute channel
// - address 00 first, 01 second channel
//
module sac_core (
    // core clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // serial link pins
    input wire logic shift_clk_i,
    input wire logic latch_i,
    input wire logic data_i,
    output logic chain_o,
    // channel 0 tap control
    output logic [`SAC_BYTE_W-1:0] ch0_tap_o,
    output logic ch0_connect_o,
    // channel 1 tap control
    output logic [`SAC_BYTE_W-1:0] ch1_tap_o,
    output logic ch1_connect_o
);
    logic [`SAC_WORD_W-1:0] word_w; // captured word, link domain
    logic cap_tgl_w; // capture toggle, link domain
    logic cap_tgl_s; // toggle after synchroniser
    logic cap_seen_reg; // synchronised toggle of the previous cycle, also tracked during warm-up
    logic cap_seen_next;
    logic cap_pulse; // one core cycle per capture
    logic [`SAC_BYTE_W-1:0] tap_reg [`SAC_CH_COUNT]; // tap per channel
    logic [`SAC_BYTE_W-1:0] tap_next [`SAC_CH_COUNT];
    sac_pkg::sac_ch_mode_t mode_reg [`SAC_CH_COUNT]; // mute state per channel
    sac_pkg::sac_ch_mode_t mode_next [`SAC_CH_COUNT];
    logic [`SAC_BYTE_W-1:0] addr_w; // address byte
    logic [`SAC_BYTE_W-1:0] attn_w; // attenuation byte
    logic [`SAC_BYTE_W-1:0] dec_tap; // decoded tap index
    logic dec_mute; // decoded mute
    logic [`SAC_CH_COUNT-1:0] sel_w; // channel select
    // warm-up after reset: the synchroniser refills from the toggle, and a toggle
    // left odd by earlier captures would look fresh and replay a stale word
    logic [`SAC_WARM_W-1:0] warm_reg; // core cycles since reset, saturating
    logic [`SAC_WARM_W-1:0] warm_next;
    logic warm_done; // synchroniser holds the live toggle

    // link-side shifter and holding latch
    sac_shifter u_shifter (
        .shift_clk_i(shift_clk_i),
        .latch_i(latch_i),
        .data_i(data_i),
        .chain_o(chain_o),
        .word_o(word_w),
        .cap_tgl_o(cap_tgl_w)
    );

    // capture toggle into core domain
    sac_sync u_cap_sync (
        .clk_i(core_clk_i),
        .rst_i(rst_i),
        .d_i(cap_tgl_w),
        .q_o(cap_tgl_s)
    );

    // word is stable in holding latch until next capture
    assign addr_w = word_w[`SAC_ADDR_MSB:`SAC_ADDR_LSB];
    assign attn_w = word_w[`SAC_ATTN_MSB:`SAC_ATTN_LSB];

    // edge detect on the synchronised toggle, masked until the synchroniser refilled;
    // a capture that lands inside the warm-up is lost, so hosts wait a few cycles
    always_comb begin
        cap_seen_next = cap_tgl_s;
        warm_done = (warm_reg == `SAC_WARM_DONE);
        warm_next = warm_done ? warm_reg : warm_reg + `SAC_WARM_STEP;
        cap_pulse = (cap_tgl_s ^ cap_seen_reg) && warm_done;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cap_seen_reg <= `SAC_ACK_RST;
            warm_reg <= `SAC_WARM_RST;
        end else begin
            cap_seen_reg <= cap_seen_next;
            warm_reg <= warm_next;
        end
    end

    // attenuation code to tap index
    always_comb begin
        dec_mute = 1'b0;
        dec_tap = attn_w;
        if (attn_w >= `SAC_CODE_MUTE_MIN) begin
            dec_mute = 1'b1;
            dec_tap = `SAC_TAP_MUTE;
        end else if (attn_w <= `SAC_CODE_HALF_MAX) begin
            dec_tap = attn_w;
        end else begin
            dec_tap = `SAC_TAP_FINE_BASE + (attn_w - `SAC_CODE_FINE_BASE);
        end
    end

    // address decode, unknown address selects nothing
    always_comb begin
        sel_w = '0;
        if (addr_w == `SAC_ADDR_CH0) begin
            sel_w[0] = 1'b1;
        end else if (addr_w == `SAC_ADDR_CH1) begin
            sel_w[1] = 1'b1;
        end else begin
            sel_w = '0;
        end
    end

    // per-channel state
    for (genvar ch = 0; ch < `SAC_CH_COUNT; ch++) begin : g_ch
        // next tap: only when addressed
        always_comb begin
            tap_next[ch] = tap_reg[ch];
            mode_next[ch] = mode_reg[ch];
            if (cap_pulse && sel_w[ch]) begin
                tap_next[ch] = dec_tap;
                mode_next[ch] = dec_mute ? sac_pkg::SAC_CH_MUTED
                                         : sac_pkg::SAC_CH_TAPPED;
            end
        end

        always_ff @(posedge core_clk_i) begin
            if (rst_i) begin
                tap_reg[ch] <= `SAC_TAP_MUTE;
                mode_reg[ch] <= sac_pkg::SAC_CH_MUTED;
            end else begin
                tap_reg[ch] <= tap_next[ch];
                mode_reg[ch] <= mode_next[ch];
            end
        end
    end

    // outputs straight from flip-flops
    logic ch0_conn_reg; // channel 0 connected
    logic ch1_conn_reg; // channel 1 connected
    logic ch0_conn_next;
    logic ch1_conn_next;

    // disconnect fully while muted
    always_comb begin
        ch0_conn_next = (mode_next[0] == sac_pkg::SAC_CH_TAPPED);
        ch1_conn_next = (mode_next[1] == sac_pkg::SAC_CH_TAPPED);
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ch0_conn_reg <= 1'b0;
            ch1_conn_reg <= 1'b0;
        end else begin
            ch0_conn_reg <= ch0_conn_next;
            ch1_conn_reg <= ch1_conn_next;
        end
    end

    assign ch0_tap_o = tap_reg[0];
    assign ch1_tap_o = tap_reg[1];
    assign ch0_connect_o = ch0_conn_reg;
    assign ch1_connect_o = ch1_conn_reg;

    // helper: decode outputs one cycle back
    logic mute_d;
    logic [`SAC_BYTE_W-1:0] tap_d;
    always_ff @(posedge core_clk_i) begin
        mute_d <= dec_mute;
        tap_d <= dec_tap;
    end

    // addressed channel 0 takes decoded tap
    property p_tap_load;
        @(posedge core_clk_i) disable iff (rst_i)
        (cap_pulse && sel_w[0]) |=> (ch0_tap_o == tap_d);
    endproperty
    a_tap_load: assert property (p_tap_load) else $error("tap not loaded");

    // unaddressed channel 1 keeps tap
    property p_hold;
        @(posedge core_clk_i) disable iff (rst_i)
        !(cap_pulse && sel_w[1]) |=> $stable(ch1_tap_o);
    endproperty
    a_hold: assert property (p_hold) else $error("tap changed unaddressed");

    // mute code disconnects channel 0 within two cycles
    property p_mute;
        @(posedge core_clk_i) disable iff (rst_i)
        (cap_pulse && sel_w[0] && dec_mute) |=> ##1 !ch0_connect_o;
    endproperty
    a_mute: assert property (p_mute) else $error("mute not applied");

    // muted tap code implies disconnection
    property p_disc;
        @(posedge core_clk_i) disable iff (rst_i)
        (ch1_tap_o == `SAC_TAP_MUTE) |-> !ch1_connect_o;
    endproperty
    a_disc: assert property (p_disc) else $error("muted but connected");

    // after reset both muted
    property p_reset;
        @(posedge core_clk_i)
        $fell(rst_i) |-> (!ch0_connect_o && !ch1_connect_o);
    endproperty
    a_reset: assert property (p_reset) else $error("not muted after reset");

    // bad address changes nothing
    property p_badaddr;
        @(posedge core_clk_i) disable iff (rst_i)
        (cap_pulse && sel_w == '0) |=> ($stable(ch0_tap_o) && $stable(ch1_tap_o));
    endproperty
    a_badaddr: assert property (p_badaddr) else $error("bad address acted");

    // fine range tap stays below mute
    property p_fine;
        @(posedge core_clk_i) disable iff (rst_i)
        (attn_w < `SAC_CODE_MUTE_MIN) |-> (!dec_mute && dec_tap == attn_w);
    endproperty
    a_fine: assert property (p_fine) else $error("tap code wrong");

    // capture pulse is one cycle
    property p_pulse;
        @(posedge core_clk_i) disable iff (rst_i)
        cap_pulse |=> !cap_pulse;
    endproperty
    a_pulse: assert property (p_pulse) else $error("capture pulse long");

    // channel 1 writes leave channel 0 tap unchanged
    property p_indep;
        @(posedge core_clk_i) disable iff (rst_i)
        (cap_pulse && sel_w[1]) |=> $stable(ch0_tap_o);
    endproperty
    a_indep: assert property (p_indep) else $error("channels coupled");

    // channel 1 takes decoded tap
    property p_tap_load1;
        @(posedge core_clk_i) disable iff (rst_i)
        (cap_pulse && sel_w[1]) |=> (ch1_tap_o == tap_d);
    endproperty
    a_tap_load1: assert property (p_tap_load1) else $error("tap 1 not loaded");

    // connect follows decoded mute, channel 0
    property p_conn0;
        @(posedge core_clk_i) disable iff (rst_i)
        (cap_pulse && sel_w[0]) |=> (ch0_connect_o == !mute_d);
    endproperty
    a_conn0: assert property (p_conn0) else $error("connect 0 wrong");

    // connect follows decoded mute, channel 1
    property p_conn1;
        @(posedge core_clk_i) disable iff (rst_i)
        (cap_pulse && sel_w[1]) |=> (ch1_connect_o == !mute_d);
    endproperty
    a_conn1: assert property (p_conn1) else $error("connect 1 wrong");

    // unaddressed channel 0 keeps tap and connection
    property p_hold0;
        @(posedge core_clk_i) disable iff (rst_i)
        !(cap_pulse && sel_w[0]) |=> ($stable(ch0_tap_o) && $stable(ch0_connect_o));
    endproperty
    a_hold0: assert property (p_hold0) else $error("channel 0 changed unaddressed");

    // mute code disconnects channel 1 within two cycles
    property p_mute1;
        @(posedge core_clk_i) disable iff (rst_i)
        (cap_pulse && sel_w[1] && dec_mute) |=> ##1 !ch1_connect_o;
    endproperty
    a_mute1: assert property (p_mute1) else $error("mute 1 not applied");

    // a connected channel 0 always sits on a step tap
    property p_step;
        @(posedge core_clk_i) disable iff (rst_i)
        ch0_connect_o |-> (ch0_tap_o < `SAC_CODE_MUTE_MIN);
    endproperty
    a_step: assert property (p_step) else $error("connected off the steps");

    // no stale word replayed after reset, taps stay muted through warm-up
    property p_warm;
        @(posedge core_clk_i)
        $fell(rst_i) |-> (ch0_tap_o == `SAC_TAP_MUTE && ch1_tap_o == `SAC_TAP_MUTE) [*4];
    endproperty
    a_warm: assert property (p_warm) else $error("stale word after reset");

    c_ch0: cover property (@(posedge core_clk_i) cap_pulse && sel_w[0] && !dec_mute);
    c_ch1: cover property (@(posedge core_clk_i) cap_pulse && sel_w[1]);
    c_mute: cover property (@(posedge core_clk_i) cap_pulse && dec_mute);
    c_bad: cover property (@(posedge core_clk_i) cap_pulse && sel_w == '0);
    c_fine: cover property (@(posedge core_clk_i) cap_pulse && attn_w >= `SAC_CODE_FINE_BASE && !dec_mute);
endmodule // sac_core

//--- dv/sac_host_model.sv
`timescale 1ns/1ps
// host end of the three-wire link; shift clock stands still between frames except while stray_clocks runs
module sac_host_model (
    // link pins towards the first device
    output logic shift_clk_o,
    output logic latch_o,
    output logic data_o,
    // chain output of the last device
    input wire logic chain_i
);
    localparam time HALF = 32ns; // half of the 64 ns link clock
    logic [31:0] chain_cap; // chain output bits, oldest in the msb
    // idle: strobe high, clock low
    initial begin
        shift_clk_o = 1'b0;
        latch_o = 1'b1;
        data_o = 1'b0;
        chain_cap = 32'h0000_0000;
    end
    // n bits msb first with the strobe low; strobe left low
    task automatic shift_bits(input logic [31:0] bits, input int n);
        latch_o = 1'b0;
        #(HALF);
        for (int i = n - 1; i >= 0; i--) begin
            data_o = bits[i];
            #(HALF);
            // far-end bit is read before the edge that passes it on
            chain_cap = {chain_cap[30:0], chain_i};
            shift_clk_o = 1'b1;
            #(HALF);
            shift_clk_o = 1'b0;
        end
        // released line no longer shows the last bit
        data_o = ~data_o;
    endtask
    // rising strobe loads every device at once
    task automatic load();
        #(HALF);
        latch_o = 1'b1;
        #(HALF);
    endtask
    // stray clocks with the strobe high, ignored by the devices
    task automatic stray_clocks(input int n);
        repeat (n) begin
            data_o = ~data_o;
            #(HALF);
            shift_clk_o = 1'b1;
            #(HALF);
            shift_clk_o = 1'b0;
        end
    endtask
endmodule // sac_host_model

//--- dv/sac_core_tb_top.sv
`timescale 1ns/1ps
`include "sac_defines.svh"
// two chained devices driven by the host model
module sac_core_tb_top;
    // compare helper
    `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
    logic core_clk_i = 1'b0; // core clock
    logic rst_i = 1'b1; // reset
    logic sclk, latch, din, mid, cout; // link nets; mid joins the devices
    logic [7:0] tap [4]; // taps: first ch0, ch1, last ch0, ch1
    logic con [4]; // connect flags, same order
    logic [7:0] exp_tap [4]; // expected taps
    logic exp_con [4]; // expected connect flags
    logic [31:0] prev_words; // words held in the chain, last device high
    logic prev_ok = 1'b0; // chain content known
    int error_cnt = 0;
    int total_checks = 0;
    // 100 MHz core clock
    always #5 core_clk_i = ~core_clk_i;
    sac_host_model host (.shift_clk_o(sclk), .latch_o(latch), .data_o(din), .chain_i(cout));
    sac_core DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .shift_clk_i(sclk), .latch_i(latch),
        .data_i(din), .chain_o(mid), .ch0_tap_o(tap[0]), .ch0_connect_o(con[0]),
        .ch1_tap_o(tap[1]), .ch1_connect_o(con[1]));
    sac_core dut_last (.core_clk_i(core_clk_i), .rst_i(rst_i), .shift_clk_i(sclk),
        .latch_i(latch), .data_i(mid), .chain_o(cout), .ch0_tap_o(tap[2]),
        .ch0_connect_o(con[2]), .ch1_tap_o(tap[3]), .ch1_connect_o(con[3]));
    // verdict and end of run
    task automatic conclude();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // all channel outputs against expectation
    task automatic check_all();
        for (int i = 0; i < 4; i++) begin
            `CHK(tap[i], exp_tap[i])
            `CHK(con[i], exp_con[i])
        end
    endtask
    // expected effect of one word on device dev
    task automatic expect_word(input int dev, input logic [15:0] w);
        if (w[15:8] < 8'h02) begin
            exp_tap[dev * 2 + w[8]] = (w[7:0] >= `SAC_CODE_MUTE_MIN) ? `SAC_TAP_MUTE : w[7:0];
            exp_con[dev * 2 + w[8]] = (w[7:0] < `SAC_CODE_MUTE_MIN);
        end
    endtask
    // one frame: word for the last device shifted first, then for the first
    task automatic send(input logic [15:0] w_first, input logic [15:0] w_last);
        host.shift_bits({w_last, w_first}, 32);
        @(negedge core_clk_i);
        check_all();
        if (prev_ok) `CHK(host.chain_cap, prev_words)
        host.load();
        repeat (8) @(negedge core_clk_i);
        expect_word(0, w_first);
        expect_word(1, w_last);
        prev_words = {w_last, w_first};
        prev_ok = 1'b1;
        check_all();
    endtask
    // power-up state
    task automatic t_reset();
        for (int i = 0; i < 4; i++) begin
            exp_tap[i] = `SAC_TAP_MUTE;
            exp_con[i] = 1'b0;
        end
        check_all();
    endtask
    // both address values, both step ranges
    task automatic t_settings();
        send(16'h0000, 16'h017E);
        send(16'h015F, 16'h0060);
    endtask
    // mute from a tapped setting, lowest and highest mute codes
    task automatic t_mute();
        send(16'h007F, 16'h01FF);
    endtask
    // stray clocks, then unknown addresses
    task automatic t_unknown();
        host.stray_clocks(5);
        send(16'h0210, 16'hFF33);
        send(16'h0123, 16'h0001);
    endtask
    // reset in mid-run with an odd capture count: muted, no stale word
    task automatic t_restart();
        @(negedge core_clk_i);
        rst_i <= 1'b1;
        repeat (8) @(negedge core_clk_i);
        rst_i <= 1'b0;
        repeat (8) @(negedge core_clk_i);
        t_reset();
        send(16'h0042, 16'h0101);
    endtask
    // hang guard
    initial begin
        #200us;
        error_cnt++;
        conclude();
    end
    // main sequence
    initial begin
        repeat (8) @(negedge core_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(negedge core_clk_i);
        t_reset();
        t_settings();
        t_mute();
        t_unknown();
        t_restart();
        conclude();
    end
endmodule // sac_core_tb_top
